// File: rtl/qdec_pkg.sv
// Constants, field layouts and carrier types of the quadrature position decoder.
package qdec_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] QDEC_SETUP_ADDR = 16'ha070;
    localparam logic [15:0] QDEC_FLAGS_ADDR = 16'ha071;
    localparam logic [15:0] QDEC_CTRL_ADDR = 16'ha072;
    localparam logic [15:0] QDEC_CNT_LO_ADDR = 16'ha074;
    localparam logic [15:0] QDEC_CNT_HI_ADDR = 16'ha075;
    localparam logic [15:0] QDEC_LIM_LO_ADDR = 16'ha076;
    localparam logic [15:0] QDEC_LIM_HI_ADDR = 16'ha077;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int QDEC_SETUP_MODE_LSB = 6;
    localparam int QDEC_SETUP_DIV_LSB = 4;
    localparam int QDEC_SETUP_SWAP_BIT = 3;
    localparam int QDEC_SETUP_FILT_LSB = 0;
    localparam int QDEC_FLAG_DIR_BIT = 7;
    localparam int QDEC_FLAG_FAULT_BIT = 6;
    localparam int QDEC_FLAG_RELOAD_LSB = 4;
    localparam int QDEC_FLAG_LIMIT_BIT = 3;
    localparam int QDEC_FLAG_MARKER_BIT = 2;
    localparam int QDEC_FLAG_WAY_BIT = 1;
    localparam int QDEC_FLAG_STEP_BIT = 0;
    localparam int QDEC_CTRL_LIMIT_IE_BIT = 7;
    localparam int QDEC_CTRL_MARKER_IE_BIT = 6;
    localparam int QDEC_CTRL_WAY_IE_BIT = 5;
    localparam int QDEC_CTRL_STEP_IE_BIT = 4;
    localparam int QDEC_CTRL_FAULT_IE_BIT = 3;
    localparam int QDEC_CTRL_MARKER_EN_BIT = 2;
    localparam int QDEC_CTRL_GATE_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] QDEC_SETUP_RST = 8'h00;
    localparam logic [7:0] QDEC_CTRL_RST = 8'h00;
    localparam logic [15:0] QDEC_COUNT_RST = 16'h0000;
    localparam logic [15:0] QDEC_LIMIT_RST = 16'h0000;

    // ****************************************
    // Divider masks and filter depth
    // ****************************************
    localparam logic [7:0] QDEC_DIV4_MASK = 8'h03;
    localparam logic [7:0] QDEC_DIV16_MASK = 8'h0f;
    localparam logic [7:0] QDEC_DIV64_MASK = 8'h3f;
    localparam logic [7:0] QDEC_DIV256_MASK = 8'hff;
    localparam int QDEC_FILT_STAGES = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {QDEC_OFF, QDEC_X1, QDEC_X2, QDEC_X4} qdec_mode_t;
    typedef enum logic [1:0] {QDEC_RLD_NONE, QDEC_RLD_MARKER, QDEC_RLD_LIMIT, QDEC_RLD_BOTH}
        qdec_reload_t;

    typedef struct packed {
        logic fault;
        logic limit;
        logic marker;
        logic way;
        logic step;
    } qdec_evt_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } qdec_bus_t;

endpackage

// File: rtl/qdec_top.sv
// Quadrature position decoder with register port and capture trigger output.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps

module qdec_top
    import qdec_pkg::*;
(
    // Clock and reset
    input logic clock_i,
    input logic sys_rst_i,
    // Register port
    input qdec_bus_t bus_i,
    output logic [7:0] rd_data_o,
    // Encoder inputs
    input logic quad_input_a_i,
    input logic quad_input_b_i,
    input logic marker_i,
    // Timer capture link
    input logic decoder_capture_enable_i,
    input logic capture_source_i,
    output logic capture_trigger_o,
    // Status
    output logic irq_request_o,
    output logic direction_o,
    output qdec_evt_t events_o
);

    // ****************************************
    // Registers and nets
    // ****************************************
    logic [7:0] setup_q;
    logic [7:0] ctrl_q;
    logic [1:0] reload_q;
    logic [15:0] limit_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] preset_q;
    logic [7:0] pre_q;
    qdec_evt_t flags_q;
    qdec_evt_t evt;
    logic dir_q;
    logic dir_d;
    logic [2:0] raw;
    logic [2:0] filt_q;
    logic prev_a_q;
    logic prev_b_q;
    logic prev_mg_q;
    logic dec_tick;
    logic filt_tick;
    logic [7:0] dec_mask;
    logic [7:0] filt_mask;
    logic [2:0] filt_code;
    qdec_mode_t mode;
    qdec_reload_t policy;
    logic pa;
    logic pb;
    logic chg_a;
    logic chg_b;
    logic step;
    logic up;
    logic mk_gated;
    logic gate_pass;
    logic [15:0] lim15;
    logic wr_flags;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic [7:0] rd_mux;

    assign mode = qdec_mode_t'(setup_q[QDEC_SETUP_MODE_LSB +: 2]);
    assign policy = qdec_reload_t'(reload_q);
    assign filt_code = setup_q[QDEC_SETUP_FILT_LSB +: 3];
    assign wr_flags = bus_i.wr && (bus_i.addr == QDEC_FLAGS_ADDR);
    // Count writes only load the counter while the decoder is off; otherwise only preset_q keeps the byte.
    assign wr_cnt_lo = bus_i.wr && (bus_i.addr == QDEC_CNT_LO_ADDR) && (mode == QDEC_OFF);
    assign wr_cnt_hi = bus_i.wr && (bus_i.addr == QDEC_CNT_HI_ADDR) && (mode == QDEC_OFF);
    assign lim15 = {1'b0, limit_q[14:0]};
    assign direction_o = dir_q;

    // ****************************************
    // Clock prescaler
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end

    always_comb begin
        unique case (setup_q[QDEC_SETUP_DIV_LSB +: 2])
            2'b00: dec_mask = QDEC_DIV4_MASK;
            2'b01: dec_mask = QDEC_DIV16_MASK;
            2'b10: dec_mask = QDEC_DIV64_MASK;
            2'b11: dec_mask = QDEC_DIV256_MASK;
        endcase
        filt_mask = 8'((9'h001 << filt_code) - 9'h001);
    end

    assign dec_tick = &(pre_q | ~dec_mask);
    assign filt_tick = &(pre_q | ~filt_mask);

    // ****************************************
    // Input de-bounce
    // ****************************************
    assign raw = {marker_i, quad_input_b_i, quad_input_a_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            logic [QDEC_FILT_STAGES-2:0] hist_q;
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    hist_q <= '0;
                    filt_q[gi] <= 1'b0;
                end else if (filt_code == 3'b000) begin
                    hist_q <= {(QDEC_FILT_STAGES-1){raw[gi]}};
                    filt_q[gi] <= raw[gi];
                end else if (filt_tick) begin
                    hist_q <= {hist_q[QDEC_FILT_STAGES-3:0], raw[gi]};
                    // A level is taken only when three filter samples agree.
                    if ((&{hist_q, raw[gi]}) || !(|{hist_q, raw[gi]})) begin
                        filt_q[gi] <= raw[gi];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Phase decode
    // ****************************************
    assign pa = setup_q[QDEC_SETUP_SWAP_BIT] ? filt_q[1] : filt_q[0];
    assign pb = setup_q[QDEC_SETUP_SWAP_BIT] ? filt_q[0] : filt_q[1];
    assign chg_a = pa ^ prev_a_q;
    assign chg_b = pb ^ prev_b_q;
    assign up = pa ^ prev_b_q;

    always_comb begin
        step = 1'b0;
        unique case (mode)
            QDEC_OFF: step = 1'b0;
            QDEC_X1: step = chg_a && !chg_b && !pb;
            QDEC_X2: step = chg_a && !chg_b;
            QDEC_X4: step = chg_a ^ chg_b;
        endcase
        step = step && dec_tick;
        unique case (ctrl_q[QDEC_CTRL_GATE_LSB +: 2])
            2'b00: gate_pass = 1'b1;
            2'b01: gate_pass = pa;
            2'b10: gate_pass = pb;
            2'b11: gate_pass = pa && pb;
        endcase
        if (mode == QDEC_X1) begin
            gate_pass = 1'b1;
        end
    end

    assign mk_gated = filt_q[2] && ctrl_q[QDEC_CTRL_MARKER_EN_BIT] && gate_pass;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            prev_a_q <= 1'b0;
            prev_b_q <= 1'b0;
            prev_mg_q <= 1'b0;
        end else if (dec_tick) begin
            prev_a_q <= pa;
            prev_b_q <= pb;
            prev_mg_q <= mk_gated;
        end
    end

    // ****************************************
    // Events and counter
    // ****************************************
    assign dir_d = step ? up : dir_q;

    always_comb begin
        evt.fault = dec_tick && (mode != QDEC_OFF) && chg_a && chg_b;
        evt.marker = dec_tick && (mode != QDEC_OFF) && mk_gated && !prev_mg_q;
        evt.limit = step && (up ? (count_q == lim15) : (count_q == 16'h0000));
        evt.way = step && (up != dir_q);
        count_d = count_q;
        if (wr_cnt_lo) begin
            count_d = {preset_q[15:8], bus_i.wdata};
        end else if (wr_cnt_hi) begin
            count_d = {bus_i.wdata, preset_q[7:0]};
        end else if (evt.marker && (policy == QDEC_RLD_MARKER || policy == QDEC_RLD_BOTH)) begin
            count_d = dir_d ? 16'h0000 : lim15;
        end else if (evt.limit && (policy == QDEC_RLD_LIMIT || policy == QDEC_RLD_BOTH)) begin
            count_d = up ? 16'h0000 : lim15;
        end else if (step) begin
            // Plain stepping wraps freely through both ends of the range.
            count_d = up ? count_q + 16'h0001 : count_q - 16'h0001;
        end
        evt.step = (mode != QDEC_OFF) && (count_d != count_q);
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count_q <= QDEC_COUNT_RST;
            dir_q <= 1'b0;
        end else begin
            count_q <= count_d;
            dir_q <= dir_d;
        end
    end

    // ****************************************
    // Event flags
    // ****************************************
    // A hardware set in the same cycle as a software clear keeps the flag set.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q.fault <= evt.fault ||
                (flags_q.fault && !(wr_flags && !bus_i.wdata[QDEC_FLAG_FAULT_BIT]));
            flags_q.limit <= evt.limit ||
                (flags_q.limit && !(wr_flags && !bus_i.wdata[QDEC_FLAG_LIMIT_BIT]));
            flags_q.marker <= evt.marker ||
                (flags_q.marker && !(wr_flags && !bus_i.wdata[QDEC_FLAG_MARKER_BIT]));
            flags_q.way <= evt.way ||
                (flags_q.way && !(wr_flags && !bus_i.wdata[QDEC_FLAG_WAY_BIT]));
            flags_q.step <= evt.step ||
                (flags_q.step && !(wr_flags && !bus_i.wdata[QDEC_FLAG_STEP_BIT]));
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            setup_q <= QDEC_SETUP_RST;
            ctrl_q <= QDEC_CTRL_RST;
            reload_q <= 2'b00;
            limit_q <= QDEC_LIMIT_RST;
            preset_q <= QDEC_COUNT_RST;
        end else if (bus_i.wr) begin
            unique case (bus_i.addr)
                QDEC_SETUP_ADDR: setup_q <= bus_i.wdata;
                QDEC_CTRL_ADDR: ctrl_q <= bus_i.wdata;
                QDEC_FLAGS_ADDR: reload_q <= bus_i.wdata[QDEC_FLAG_RELOAD_LSB +: 2];
                QDEC_LIM_LO_ADDR: limit_q[7:0] <= bus_i.wdata;
                QDEC_LIM_HI_ADDR: limit_q[15:8] <= bus_i.wdata;
                QDEC_CNT_LO_ADDR: preset_q[7:0] <= bus_i.wdata;
                QDEC_CNT_HI_ADDR: preset_q[15:8] <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // ****************************************
    // Read port and outputs
    // ****************************************
    always_comb begin
        unique case (bus_i.addr)
            QDEC_SETUP_ADDR: rd_mux = setup_q;
            QDEC_FLAGS_ADDR: rd_mux = {dir_q, flags_q.fault, reload_q, flags_q.limit,
                flags_q.marker, flags_q.way, flags_q.step};
            QDEC_CTRL_ADDR: rd_mux = ctrl_q;
            QDEC_CNT_LO_ADDR: rd_mux = count_q[7:0];
            QDEC_CNT_HI_ADDR: rd_mux = count_q[15:8];
            QDEC_LIM_LO_ADDR: rd_mux = limit_q[7:0];
            QDEC_LIM_HI_ADDR: rd_mux = limit_q[15:8];
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 8'h00;
            irq_request_o <= 1'b0;
            capture_trigger_o <= 1'b0;
            events_o <= '0;
        end else begin
            rd_data_o <= bus_i.rd ? rd_mux : 8'h00;
            irq_request_o <= (flags_q.limit && ctrl_q[QDEC_CTRL_LIMIT_IE_BIT]) ||
                (flags_q.marker && ctrl_q[QDEC_CTRL_MARKER_IE_BIT]) ||
                (flags_q.way && ctrl_q[QDEC_CTRL_WAY_IE_BIT]) ||
                (flags_q.step && ctrl_q[QDEC_CTRL_STEP_IE_BIT]) ||
                (flags_q.fault && ctrl_q[QDEC_CTRL_FAULT_IE_BIT]);
            capture_trigger_o <= decoder_capture_enable_i &&
                (capture_source_i ? evt.limit : evt.marker);
            events_o <= evt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_tick_gap;
        !dec_tick [*3] ##1 dec_tick;
    endsequence

    a_tick_div_four: assert property ((setup_q[5:4] == 2'b00) && dec_tick && !bus_i.wr
        |=> s_tick_gap) else $error("decoder tick spacing wrong");
    a_off_holds_count: assert property ((mode == QDEC_OFF) && !wr_cnt_lo && !wr_cnt_hi
        |=> $stable(count_q)) else $error("count moved while off");
    a_fault_sets: assert property (evt.fault |=> flags_q.fault)
        else $error("phase fault not flagged");
    a_fault_sticky: assert property (flags_q.fault && !wr_flags |=> flags_q.fault)
        else $error("phase fault dropped");
    a_marker_gated: assert property (!ctrl_q[QDEC_CTRL_MARKER_EN_BIT] |-> !evt.marker)
        else $error("marker passed while disabled");
    a_wrap_up: assert property ((policy == QDEC_RLD_NONE) && step && up && !evt.marker
        && (count_q == 16'hffff) |=> count_q == 16'h0000) else $error("no wrap");
    a_limit_reload: assert property ((policy == QDEC_RLD_LIMIT) && evt.limit && up
        |=> count_q == 16'h0000) else $error("terminal reload missed");
    a_marker_reload: assert property ((policy == QDEC_RLD_MARKER) && evt.marker && dir_d
        |=> count_q == 16'h0000) else $error("marker reload missed");
    a_irq_gate: assert property (flags_q.step && ctrl_q[QDEC_CTRL_STEP_IE_BIT]
        |=> irq_request_o) else $error("enabled flag gave no request");
    a_irq_masked: assert property (ctrl_q[QDEC_CTRL_LIMIT_IE_BIT -: 5] == 5'h00
        |=> !irq_request_o) else $error("request without enable");
    a_way_flag: assert property (evt.way |=> flags_q.way && (direction_o == $past(up)))
        else $error("direction change not flagged");
    a_read_data: assert property (bus_i.rd && (bus_i.addr == QDEC_CNT_HI_ADDR)
        |=> rd_data_o == $past(count_q[15:8])) else $error("count read wrong");

endmodule // qdec_top

// File: verif/qdec_encoder_model.sv
// Behavioural quadrature encoder with marker output, driven by tasks from the bench.
`timescale 1ns/1ps

module qdec_encoder_model (
    // Clock
    input wire logic clock_i,
    // Encoder outputs
    output logic quad_a_o,
    output logic quad_b_o,
    output logic marker_o
);

    // ****************************************
    // Phase state
    // ****************************************
    // Gray sequence 00, 10, 11, 01 is forward: the two phases stay a quarter cycle apart.
    logic [1:0] phase_q = 2'b00;
    logic marker_q = 1'b0;

    assign quad_a_o = phase_q[0] ^ phase_q[1];
    assign quad_b_o = phase_q[1];
    assign marker_o = marker_q;

    // ****************************************
    // Motion tasks
    // ****************************************
    // Edges are eight clocks apart, so at least one decoder tick falls between them.
    task automatic steps(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge clock_i);
            phase_q <= up ? phase_q + 2'd1 : phase_q - 2'd1;
        end
        repeat (12) @(posedge clock_i);
    endtask

    // Both phases move in one cycle, which a healthy encoder never does.
    task automatic glitch();
        repeat (8) @(posedge clock_i);
        phase_q <= phase_q + 2'd2;
        repeat (12) @(posedge clock_i);
    endtask

    task automatic index_pulse();
        repeat (8) @(posedge clock_i);
        marker_q <= 1'b1;
        repeat (12) @(posedge clock_i);
        marker_q <= 1'b0;
        repeat (12) @(posedge clock_i);
    endtask

endmodule // qdec_encoder_model

// File: verif/tb.sv
// Self-checking testbench of the quadrature position decoder.
`timescale 1ns/1ps

module tb;
    import qdec_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    qdec_bus_t bus_i = '0;
    logic [7:0] rd_data_o;
    logic quad_a, quad_b, marker;
    logic cap_en = 1'b0;
    logic cap_src = 1'b0;
    logic capture_trigger_o, irq_request_o, direction_o;
    qdec_evt_t events_o;
    int errors = 0;
    int cmp_count = 0;
    int trig_seen = 0;
    int limit_seen = 0;
    int step_seen = 0;
    int base_t, base_l, base_s;
    logic [7:0] rv;
    logic [15:0] cv;

    always #12.5 clock_i = ~clock_i;

    qdec_top qdec_top_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
        .rd_data_o(rd_data_o), .quad_input_a_i(quad_a), .quad_input_b_i(quad_b),
        .marker_i(marker), .decoder_capture_enable_i(cap_en), .capture_source_i(cap_src),
        .capture_trigger_o(capture_trigger_o), .irq_request_o(irq_request_o),
        .direction_o(direction_o), .events_o(events_o));

    qdec_encoder_model qdec_encoder_model_i (.clock_i(clock_i), .quad_a_o(quad_a),
        .quad_b_o(quad_b), .marker_o(marker));

    // Event pulses stand one cycle only, so they are counted as they pass.
    always @(posedge clock_i) begin
        if (capture_trigger_o === 1'b1) trig_seen++;
        if (events_o.limit === 1'b1) limit_seen++;
        if (events_o.step === 1'b1) step_seen++;
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus_i <= '0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock_i);
        bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus_i <= '0;
        #1;
        d = rd_data_o;
    endtask

    task automatic wr_cnt(input logic [15:0] c);
        wr(QDEC_CNT_LO_ADDR, c[7:0]);
        wr(QDEC_CNT_HI_ADDR, c[15:8]);
    endtask

    task automatic rd_cnt(output logic [15:0] c);
        rd(QDEC_CNT_LO_ADDR, c[7:0]);
        rd(QDEC_CNT_HI_ADDR, c[15:8]);
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        $display("wait limit reached");
        final_report();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(16'ha070 + 16'(i), rv);
            check("reset value", rv, 16'h0000);
        end
        wr(QDEC_CTRL_ADDR, 8'ha5);
        rd(QDEC_CTRL_ADDR, rv);
        check("control", rv, 16'h00a5);
        wr(QDEC_CTRL_ADDR, 8'h00);
        wr(16'ha073, 8'hff);
        rd(16'ha073, rv);
        check("unmapped", rv, 16'h0000);
        wr(QDEC_LIM_LO_ADDR, 8'h05);
        wr(QDEC_LIM_HI_ADDR, 8'h80);
        rd(QDEC_LIM_HI_ADDR, rv);
        check("limit high", rv, 16'h0080);
        // Preset while off, and no counting while off.
        wr_cnt(16'h1234);
        qdec_encoder_model_i.steps(4, 1'b1);
        rd_cnt(cv);
        check("count off", cv, 16'h1234);
        for (int m = 1; m < 4; m++) begin
            wr(QDEC_SETUP_ADDR, 8'h00);
            wr_cnt(16'h0100);
            wr(QDEC_FLAGS_ADDR, 8'h00);
            wr(QDEC_SETUP_ADDR, {2'(m), 6'h00});
            base_s = step_seen;
            qdec_encoder_model_i.steps(4, 1'b1);
            rd_cnt(cv);
            check("count mode", cv, m == 1 ? 16'h0101 : (m == 2 ? 16'h0102 : 16'h0104));
            check("step pulses", 16'(step_seen - base_s),
                m == 1 ? 16'h0001 : (m == 2 ? 16'h0002 : 16'h0004));
            rd(QDEC_FLAGS_ADDR, rv);
            check("flags mode", rv, m == 1 ? 16'h0083 : 16'h0081);
        end
        wr(QDEC_CNT_LO_ADDR, 8'h77);
        rd_cnt(cv);
        check("count write on", cv, 16'h0104);
        wr(QDEC_SETUP_ADDR, 8'h00);
        wr_cnt(16'h0100);
        wr(QDEC_SETUP_ADDR, 8'hc8);
        qdec_encoder_model_i.steps(4, 1'b1);
        rd_cnt(cv);
        check("count swap", cv, 16'h00fc);
        check("direction", direction_o, 16'h0000);
        wr(QDEC_SETUP_ADDR, 8'h00);
        wr_cnt(16'h0000);
        wr(QDEC_SETUP_ADDR, 8'hc0);
        qdec_encoder_model_i.steps(1, 1'b0);
        rd_cnt(cv);
        check("count wrap", cv, 16'hffff);
        qdec_encoder_model_i.steps(1, 1'b1);
        rd_cnt(cv);
        check("count wrap up", cv, 16'h0000);
        // Terminal reload with the limit's top bit set, which must not matter.
        wr(QDEC_SETUP_ADDR, 8'h00);
        wr_cnt(16'h0005);
        wr(QDEC_FLAGS_ADDR, 8'h20);
        wr(QDEC_CTRL_ADDR, 8'h80);
        @(posedge clock_i);
        cap_en <= 1'b1;
        cap_src <= 1'b1;
        base_t = trig_seen;
        base_l = limit_seen;
        wr(QDEC_SETUP_ADDR, 8'hc0);
        qdec_encoder_model_i.steps(1, 1'b1);
        rd_cnt(cv);
        check("count terminal", cv, 16'h0000);
        rd(QDEC_FLAGS_ADDR, rv);
        check("flags terminal", rv, 16'h00a9);
        check("irq", irq_request_o, 16'h0001);
        check("limit pulses", 16'(limit_seen - base_l), 16'h0001);
        check("triggers", 16'(trig_seen - base_t), 16'h0001);
        wr(QDEC_FLAGS_ADDR, 8'h20);
        repeat (2) @(posedge clock_i);
        check("irq cleared", irq_request_o, 16'h0000);
        // Marker reload, first with the marker input gated off.
        wr(QDEC_FLAGS_ADDR, 8'h10);
        wr(QDEC_CTRL_ADDR, 8'h00);
        @(posedge clock_i);
        cap_src <= 1'b0;
        qdec_encoder_model_i.steps(2, 1'b1);
        base_t = trig_seen;
        qdec_encoder_model_i.index_pulse();
        rd_cnt(cv);
        check("count masked", cv, 16'h0002);
        wr(QDEC_CTRL_ADDR, 8'h04);
        qdec_encoder_model_i.index_pulse();
        rd_cnt(cv);
        check("count marker", cv, 16'h0000);
        rd(QDEC_FLAGS_ADDR, rv);
        check("flags marker", rv, 16'h0095);
        check("marker triggers", 16'(trig_seen - base_t), 16'h0001);
        // Marker gating by phase level: phase A is low and phase B is high here.
        wr(QDEC_FLAGS_ADDR, 8'h10);
        wr(QDEC_CTRL_ADDR, 8'h05);
        qdec_encoder_model_i.index_pulse();
        rd(QDEC_FLAGS_ADDR, rv);
        check("gated by a", rv & 8'h04, 16'h0000);
        wr(QDEC_CTRL_ADDR, 8'h06);
        cap_en <= 1'b0;
        base_t = trig_seen;
        qdec_encoder_model_i.index_pulse();
        rd(QDEC_FLAGS_ADDR, rv);
        check("gated by b", rv & 8'h04, 16'h0004);
        check("capture off", 16'(trig_seen - base_t), 16'h0000);
        // A marker pulse shorter than three filter samples is rejected.
        wr(QDEC_FLAGS_ADDR, 8'h10);
        wr(QDEC_SETUP_ADDR, 8'hc3);
        qdec_encoder_model_i.index_pulse();
        rd(QDEC_FLAGS_ADDR, rv);
        check("filter reject", rv & 8'h04, 16'h0000);
        wr(QDEC_SETUP_ADDR, 8'hc1);
        qdec_encoder_model_i.index_pulse();
        rd(QDEC_FLAGS_ADDR, rv);
        check("filter pass", rv & 8'h04, 16'h0004);
        // Phase fault stays until software clears it.
        wr(QDEC_FLAGS_ADDR, 8'h10);
        qdec_encoder_model_i.glitch();
        repeat (20) @(posedge clock_i);
        rd(QDEC_FLAGS_ADDR, rv);
        check("fault set", rv & 8'h40, 16'h0040);
        wr(QDEC_FLAGS_ADDR, 8'h10);
        rd(QDEC_FLAGS_ADDR, rv);
        check("fault clear", rv & 8'h40, 16'h0000);
        final_report();
    end

endmodule // tb
